// *** src/bebm_pkg.sv ***
// Package for the bus event and breakpoint matcher: register map, field layouts and types.
// Assumes a 32-bit AXI4-Lite register bus and a single clock domain.
package bebm_pkg;

   localparam int NUM_CH = 12;
   localparam int NUM_GEN = 8;
   localparam int TRIG_CH = 8;
   localparam int NUM_PROBE = 4;
   localparam int NUM_STATE = 6;
   localparam int NUM_AREA = 7;

   // Per-channel register block: 5 words starting at CH_BASE, stride CH_STRIDE (8 words).
   localparam logic [11:0] CH_BASE = 12'h100;
   localparam logic [11:0] CH_STRIDE = 12'h020;
   localparam logic [2:0] CH_CFG = 3'h0;
   localparam logic [2:0] CH_ADDR_LO = 3'h1;
   localparam logic [2:0] CH_ADDR_HI = 3'h2;
   localparam logic [2:0] CH_DATA = 3'h3;
   localparam logic [2:0] CH_MASK = 3'h4;

   // Global registers.
   localparam logic [11:0] IRQ_STATUS = 12'h000;
   localparam logic [11:0] IRQ_MASK = 12'h004;
   localparam logic [11:0] MATCH_LAST = 12'h008;
   localparam logic [11:0] ENABLE_ALL = 12'h00c;

   // Configuration word field positions.
   localparam int F_EN = 0;
   localparam int F_PCBRK = 1;
   localparam int F_AMODE = 2;
   localparam int F_OUTSIDE = 4;
   localparam int F_CMP = 5;
   localparam int F_USEMASK = 6;
   localparam int F_WORD = 7;
   localparam int F_DIR = 8;
   localparam int F_STATE = 10;
   localparam int F_STATE_DC = 16;
   localparam int F_AREA = 17;
   localparam int F_AREA_DC = 24;
   localparam int F_PROBE = 25;

   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      BEBM_ADDR_DC = 2'h0,
      BEBM_ADDR_ONE = 2'h1,
      BEBM_ADDR_RANGE = 2'h2
   } bebm_amode_t;

   typedef enum logic [1:0] {
      BEBM_DIR_EITHER = 2'h0,
      BEBM_DIR_READ = 2'h1,
      BEBM_DIR_WRITE = 2'h2
   } bebm_dir_t;

   typedef enum logic [1:0] {
      BEBM_PRB_DC = 2'h0,
      BEBM_PRB_HIGH = 2'h1,
      BEBM_PRB_LOW = 2'h2
   } bebm_prb_t;

   typedef enum logic [1:0] {
      BEBM_AX_IDLE = 2'h0,
      BEBM_AX_RESP = 2'h1
   } bebm_axst_t;

   // One observed target bus cycle.
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic [15:0] data;
      logic write;
      logic word;
      logic fetch;
      logic [NUM_STATE-1:0] state;
      logic [NUM_AREA-1:0] area;
   } bebm_cyc_t;

   typedef struct packed {
      logic [31:0] cfg;
      logic [31:0] lo;
      logic [31:0] hi;
      logic [15:0] data;
      logic [15:0] mask;
   } bebm_ch_t;

endpackage : bebm_pkg

// *** src/bebm_matcher.sv ***
// Bus event and breakpoint matcher: twelve channels watching the target bus cycles.
// Assumes bus-cycle strobes arrive synchronous to aclk; probes are asynchronous pins.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module bebm_matcher #(
   parameter int NCH = bebm_pkg::NUM_CH
) (
   input wire logic aclk, // System clock, 200 MHz.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire bebm_pkg::bebm_cyc_t cyc, // Completed target bus cycle.
   input wire logic [bebm_pkg::NUM_PROBE-1:0] probe_in, // External probe pins.
   input wire logic [11:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [11:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   output logic [NCH-1:0] match_out, // One-cycle match per channel.
   output logic trigger_probe_out, // Trigger probe, active low.
   output logic irq // Level interrupt.
);

   typedef struct packed {
      bebm_pkg::bebm_ch_t [NCH-1:0] ch;
      logic [NCH-1:0][1:0] p3sel;
      logic [NCH-1:0] sts;
      logic [NCH-1:0] msk;
      logic [NCH-1:0] last;
      logic [NCH-1:0] match;
      logic trig_n;
      logic [NCH-1:0] arm;
      logic [2:0] p1;
      logic [bebm_pkg::NUM_PROBE-1:0] s1;
      logic [bebm_pkg::NUM_PROBE-1:0] s2;
      logic [bebm_pkg::NUM_PROBE-1:0] s3;
      logic [bebm_pkg::NUM_PROBE-1:0] prb;
      logic aw_got;
      logic w_got;
      logic [11:0] awa;
      logic [31:0] wd;
      logic [3:0] ws;
      bebm_pkg::bebm_axst_t wst;
      logic [1:0] bresp;
      bebm_pkg::bebm_axst_t rst;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } bebm_state_t;

   bebm_state_t st_r;
   bebm_state_t st_nxt;

   // Decodes a byte address into channel index and word; valid flag when mapped.
   function automatic logic [8:0] bebm_dec(input logic [11:0] a);
      logic [11:0] off;
      logic [3:0] idx;
      off = a - bebm_pkg::CH_BASE;
      idx = off[8:5];
      bebm_dec = {(a >= bebm_pkg::CH_BASE) && (idx < 4'(NCH)) && (off[4:2] <= 3'h4)
                  && (off[11:9] == 3'h0), 1'b0, idx, off[4:2]};
   endfunction : bebm_dec

   // Evaluates one channel's combined condition against the current bus cycle.
   function automatic logic bebm_eval(input bebm_pkg::bebm_ch_t c, input bebm_pkg::bebm_cyc_t b,
                                      input logic [bebm_pkg::NUM_PROBE-1:0] p,
                                      input logic [1:0] p3s,
                                      input logic full);
      logic am;
      logic dm;
      logic dirm;
      logic sm;
      logic arm_ok;
      logic pm;
      logic [1:0] ps;
      logic [15:0] mk;
      am = 1'b1;
      dm = 1'b1;
      pm = 1'b1;
      mk = c.cfg[bebm_pkg::F_USEMASK] ? c.mask : 16'hffff;
      case (bebm_pkg::bebm_amode_t'(c.cfg[bebm_pkg::F_AMODE +: 2]))
         bebm_pkg::BEBM_ADDR_ONE: am = (b.addr == c.lo);
         bebm_pkg::BEBM_ADDR_RANGE: am = (b.addr >= c.lo) && (b.addr <= c.hi);
         default: am = 1'b1;
      endcase
      // Outside-range negation only exists on the general channels.
      if (full && c.cfg[bebm_pkg::F_OUTSIDE] && (c.cfg[bebm_pkg::F_AMODE +: 2] != 2'h0)) begin
         am = ~am;
      end
      if (c.cfg[bebm_pkg::F_CMP]) begin
         dm = ((b.data & mk) == (c.data & mk)) && (b.word == c.cfg[bebm_pkg::F_WORD]);
      end
      case (bebm_pkg::bebm_dir_t'(c.cfg[bebm_pkg::F_DIR +: 2]))
         bebm_pkg::BEBM_DIR_READ: dirm = ~b.write;
         bebm_pkg::BEBM_DIR_WRITE: dirm = b.write;
         default: dirm = 1'b1;
      endcase
      sm = c.cfg[bebm_pkg::F_STATE_DC]
           || |(b.state & c.cfg[bebm_pkg::F_STATE +: bebm_pkg::NUM_STATE]);
      arm_ok = c.cfg[bebm_pkg::F_AREA_DC]
               || |(b.area & c.cfg[bebm_pkg::F_AREA +: bebm_pkg::NUM_AREA]);
      for (int i = 0; i < bebm_pkg::NUM_PROBE - 1; i++) begin
         ps = c.cfg[bebm_pkg::F_PROBE + 2*i +: 2];
         if (ps == 2'(bebm_pkg::BEBM_PRB_HIGH) && !p[i]) pm = 1'b0;
         if (ps == 2'(bebm_pkg::BEBM_PRB_LOW) && p[i]) pm = 1'b0;
      end
      // The last probe's select does not fit the configuration word, so it rides in the mask word.
      if (p3s == 2'(bebm_pkg::BEBM_PRB_HIGH) && !p[bebm_pkg::NUM_PROBE-1]) pm = 1'b0;
      if (p3s == 2'(bebm_pkg::BEBM_PRB_LOW) && p[bebm_pkg::NUM_PROBE-1]) pm = 1'b0;
      if (c.cfg[bebm_pkg::F_PCBRK]) begin
         bebm_eval = b.fetch && (b.addr == c.lo);
      end else begin
         bebm_eval = am && dm && dirm && sm && arm_ok && pm;
      end
   endfunction : bebm_eval

   logic [8:0] wdec;
   logic [8:0] rdec;
   logic [NCH-1:0] hit;
   logic [31:0] wmask;

   // Per-channel match, gated by enable and a valid completed cycle.
   generate
      for (genvar g = 0; g < NCH; g++) begin : g_ch
         assign hit[g] = cyc.valid && st_r.ch[g].cfg[bebm_pkg::F_EN]
                         && bebm_eval(st_r.ch[g], cyc, st_r.prb, st_r.p3sel[g],
                                      g < bebm_pkg::NUM_GEN);
      end
   endgenerate

   assign wdec = bebm_dec(st_r.awa);
   assign rdec = bebm_dec(s_axi_araddr);
   assign wmask = {{8{st_r.ws[3]}}, {8{st_r.ws[2]}}, {8{st_r.ws[1]}}, {8{st_r.ws[0]}}};

   // Next-state logic: bus slave, probe synchroniser, matching and interrupt status.
   always_comb begin
      logic [31:0] v;
      logic [NCH-1:0] clr;
      v = 32'h0;
      clr = '0;
      st_nxt = st_r;
      // Probes pass three flops; a change is accepted when the last two agree.
      st_nxt.s1 = probe_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3) st_nxt.prb = st_r.s3;
      st_nxt.match = hit;
      if (|hit) st_nxt.last = hit;
      // The trigger stays low until the next bus-cycle strobe without a channel-8 match.
      if (hit[bebm_pkg::TRIG_CH-1]) begin
         st_nxt.trig_n = 1'b0;
      end else if (cyc.valid) begin
         st_nxt.trig_n = 1'b1;
      end
      // Write channel: address and data accepted in either order.
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wd = s_axi_wdata;
         st_nxt.ws = s_axi_wstrb;
      end
      case (st_r.wst)
         bebm_pkg::BEBM_AX_IDLE: begin
            if (st_r.aw_got && st_r.w_got) begin
               st_nxt.aw_got = 1'b0;
               st_nxt.w_got = 1'b0;
               st_nxt.wst = bebm_pkg::BEBM_AX_RESP;
               st_nxt.bresp = bebm_pkg::RESP_OKAY;
               if (st_r.awa == bebm_pkg::IRQ_STATUS) begin
                  clr = st_r.wd[NCH-1:0] & wmask[NCH-1:0];
               end else if (st_r.awa == bebm_pkg::IRQ_MASK) begin
                  st_nxt.msk = (st_r.msk & ~wmask[NCH-1:0]) | (st_r.wd[NCH-1:0] & wmask[NCH-1:0]);
               end else if (wdec[8]) begin
                  case (wdec[2:0])
                     bebm_pkg::CH_CFG: st_nxt.ch[wdec[6:3]].cfg =
                        (st_r.ch[wdec[6:3]].cfg & ~wmask) | (st_r.wd & wmask);
                     bebm_pkg::CH_ADDR_LO: st_nxt.ch[wdec[6:3]].lo =
                        (st_r.ch[wdec[6:3]].lo & ~wmask) | (st_r.wd & wmask);
                     bebm_pkg::CH_ADDR_HI: st_nxt.ch[wdec[6:3]].hi =
                        (st_r.ch[wdec[6:3]].hi & ~wmask) | (st_r.wd & wmask);
                     bebm_pkg::CH_DATA: st_nxt.ch[wdec[6:3]].data =
                        (st_r.ch[wdec[6:3]].data & ~wmask[15:0]) | (st_r.wd[15:0] & wmask[15:0]);
                     default: begin
                        st_nxt.ch[wdec[6:3]].mask = (st_r.ch[wdec[6:3]].mask & ~wmask[15:0])
                           | (st_r.wd[15:0] & wmask[15:0]);
                        // Bits 17:16 of the mask word hold the last probe's select.
                        st_nxt.p3sel[wdec[6:3]] = (st_r.p3sel[wdec[6:3]] & ~wmask[17:16])
                           | (st_r.wd[17:16] & wmask[17:16]);
                     end
                  endcase
               end else if ((st_r.awa != bebm_pkg::MATCH_LAST)
                            && (st_r.awa != bebm_pkg::ENABLE_ALL)) begin
                  st_nxt.bresp = bebm_pkg::RESP_SLVERR;
               end
            end
         end
         bebm_pkg::BEBM_AX_RESP: begin
            if (s_axi_bready) st_nxt.wst = bebm_pkg::BEBM_AX_IDLE;
         end
         default: st_nxt.wst = bebm_pkg::BEBM_AX_IDLE;
      endcase
      // Sticky status: a new match wins over a clear in the same cycle.
      st_nxt.sts = (st_r.sts & ~clr) | hit;
      // Read channel.
      case (st_r.rst)
         bebm_pkg::BEBM_AX_IDLE: begin
            if (s_axi_arvalid) begin
               st_nxt.rst = bebm_pkg::BEBM_AX_RESP;
               st_nxt.rresp = bebm_pkg::RESP_OKAY;
               if (s_axi_araddr == bebm_pkg::IRQ_STATUS) begin
                  v[NCH-1:0] = st_r.sts;
               end else if (s_axi_araddr == bebm_pkg::IRQ_MASK) begin
                  v[NCH-1:0] = st_r.msk;
               end else if (s_axi_araddr == bebm_pkg::MATCH_LAST) begin
                  v[NCH-1:0] = st_r.last;
               end else if (s_axi_araddr == bebm_pkg::ENABLE_ALL) begin
                  for (int i = 0; i < NCH; i++) v[i] = st_r.ch[i].cfg[bebm_pkg::F_EN];
               end else if (rdec[8]) begin
                  case (rdec[2:0])
                     bebm_pkg::CH_CFG: v = st_r.ch[rdec[6:3]].cfg;
                     bebm_pkg::CH_ADDR_LO: v = st_r.ch[rdec[6:3]].lo;
                     bebm_pkg::CH_ADDR_HI: v = st_r.ch[rdec[6:3]].hi;
                     bebm_pkg::CH_DATA: v[15:0] = st_r.ch[rdec[6:3]].data;
                     default: begin
                        v[15:0] = st_r.ch[rdec[6:3]].mask;
                        v[17:16] = st_r.p3sel[rdec[6:3]];
                     end
                  endcase
               end else begin
                  st_nxt.rresp = bebm_pkg::RESP_SLVERR;
               end
               st_nxt.rdata = v;
            end
         end
         bebm_pkg::BEBM_AX_RESP: begin
            if (s_axi_rready) st_nxt.rst = bebm_pkg::BEBM_AX_IDLE;
         end
         default: st_nxt.rst = bebm_pkg::BEBM_AX_IDLE;
      endcase
   end

   // Single register stage for all state.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.trig_n <= 1'b1;
         st_r.s1 <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Handshake outputs come straight from the slave state.
   assign s_axi_awready = !st_r.aw_got && (st_r.wst == bebm_pkg::BEBM_AX_IDLE);
   assign s_axi_wready = !st_r.w_got && (st_r.wst == bebm_pkg::BEBM_AX_IDLE);
   assign s_axi_bvalid = (st_r.wst == bebm_pkg::BEBM_AX_RESP);
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = (st_r.rst == bebm_pkg::BEBM_AX_IDLE);
   assign s_axi_rvalid = (st_r.rst == bebm_pkg::BEBM_AX_RESP);
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign match_out = st_r.match;
   assign trigger_probe_out = st_r.trig_n;
   assign irq = |(st_r.sts & st_r.msk);

endmodule : bebm_matcher

`default_nettype wire

// *** verification/bebm_matcher_props.sv ***
// Checker for the matcher ports: match pulses, trigger probe and register bus answers.
// Sees only the top module's ports; the bind stands at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module bebm_matcher_props #(
   parameter int NCH = 12
) (
   input wire logic aclk, // Clock.
   input wire logic aresetn, // Reset, active low.
   input wire bebm_pkg::bebm_cyc_t cyc, // Observed bus cycle.
   input wire logic s_axi_awvalid, // AW valid.
   input wire logic s_axi_awready, // AW ready.
   input wire logic s_axi_wvalid, // W valid.
   input wire logic s_axi_wready, // W ready.
   input wire logic [1:0] s_axi_bresp, // B code.
   input wire logic s_axi_bvalid, // B valid.
   input wire logic s_axi_bready, // B ready.
   input wire logic s_axi_arvalid, // AR valid.
   input wire logic s_axi_arready, // AR ready.
   input wire logic [31:0] s_axi_rdata, // R data.
   input wire logic s_axi_rvalid, // R valid.
   input wire logic s_axi_rready, // R ready.
   input wire logic [NCH-1:0] match_out, // Channel matches.
   input wire logic trigger_probe_out // Trigger, active low.
);
   // One clock domain, so all checks share a clock and go quiet in reset.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_match_cause: assert property (|match_out |-> $past(cyc.valid))
      else $error("match without a bus cycle");
   a_match_single: assert property (|match_out && !cyc.valid |=> match_out == '0)
      else $error("match held past one cycle");
   a_trig_low: assert property (match_out[7] |-> !trigger_probe_out)
      else $error("trigger not low after channel 8 match");
   a_trig_cause: assert property ($fell(trigger_probe_out) |-> match_out[7])
      else $error("trigger fell without channel 8 match");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_r_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
      else $error("read answer without request");
   c_trig: cover property (match_out[7]);
   c_range: cover property (match_out[11:8] != 4'h0);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : bebm_matcher_props
bind bebm_matcher bebm_matcher_props #(.NCH(NCH)) u_props (.aclk, .aresetn, .cyc, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .match_out,
   .trigger_probe_out);
`default_nettype wire

// *** verification/bebm_bus_model.sv ***
// Model of the watched target bus: hands over one completed bus cycle per send.
// Assumes the bench calls send; idle lines carry the inverse of the last cycle.
`timescale 1ns/10ps
`default_nettype none
module bebm_bus_model (
   input wire logic aclk, // Clock.
   output var bebm_pkg::bebm_cyc_t cyc // Completed bus cycles.
);
   // Quiet lines at start so nothing is seen before the first send.
   initial cyc = '0;
   // A gap models a slow target; inverted idle lines stop stale values from matching.
   task automatic send(input bebm_pkg::bebm_cyc_t c, input int gap);
      repeat (gap) @(posedge aclk);
      @(posedge aclk);
      c.valid = 1'b1;
      cyc <= c;
      @(posedge aclk);
      c = ~c;
      c.valid = 1'b0;
      cyc <= c;
   endtask : send
endmodule : bebm_bus_model
`default_nettype wire

// *** verification/test_bus_event_breakpoint_matcher.sv ***
// Bench for the matcher: random channel setups and bus cycles, registers and interrupt.
// Assumes the bus model and the bound checker; the last probe's select is mask word bits 17:16.
`timescale 1ns/10ps
`default_nettype none
module test_bus_event_breakpoint_matcher;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] probe_in = 4'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [11:0] match_out;
   logic trigger_probe_out, irq;
   bebm_pkg::bebm_cyc_t cyc;
   bebm_pkg::bebm_ch_t chs [12];
   logic [1:0] p3s [12];
   logic [31:0] seed = 32'h897c;
   logic [11:0] seen = 12'h0;
   logic [11:0] last = 12'h0;
   int fail_count = 0;
   int samples_checked = 0;
   bebm_matcher u_bebm_matcher (.*);
   bebm_bus_model u_bus (.aclk, .cyc);
   always #2.5 aclk = ~aclk;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // Legal random setup, biased toward don't-care so that matches happen often.
   function automatic logic [31:0] mkcfg();
      logic [31:0] r;
      logic [31:0] b;
      int fld[5] = '{2, 8, 25, 27, 29};
      r = xs();
      b = xs();
      foreach (fld[k]) if (r[fld[k]+1] && r[fld[k]]) r[fld[k]+1] = 1'b0;
      r[31] = 1'b0;
      r[0] = b[0] | b[1];
      r[1] = b[2] & b[3] & b[4];
      r[5] = r[5] & b[5];
      r[16] = r[16] | b[6];
      r[24] = r[24] | b[7];
      if (b[8]) r[30:25] = 6'h0;
      return r;
   endfunction : mkcfg
   function automatic logic exp_hit(int ch, bebm_pkg::bebm_ch_t k, bebm_pkg::bebm_cyc_t c,
                                    logic [3:0] p, logic [1:0] q);
      logic [31:0] f;
      logic [15:0] m;
      logic h;
      f = k.cfg;
      if (!f[0]) return 1'b0;
      if (f[1]) return c.fetch && c.addr == k.lo;
      h = 1'b1;
      if (f[3:2] == 2'h1) h = c.addr == k.lo;
      if (f[3:2] == 2'h2) h = c.addr >= k.lo && c.addr <= k.hi;
      if (f[3:2] != 2'h0 && f[4] && ch < 8) h = !h;
      m = f[6] ? k.mask : 16'hffff;
      if (f[5]) h &= c.word == f[7] && (c.data & m) == (k.data & m);
      if (f[9:8] != 2'h0) h &= (f[9:8] == 2'h1) != c.write;
      h &= f[16] || |(f[15:10] & c.state);
      h &= f[24] || |(f[23:17] & c.area);
      for (int i = 0; i < 3; i++) begin
         if (f[25+2*i+:2] != 2'h0) h &= p[i] == (f[25+2*i+:2] == 2'h1);
      end
      if (q != 2'h0) h &= p[3] == (q == 2'h1);
      return h;
   endfunction : exp_hit
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   // Address, data and bready go out together; the task waits until the answer shows.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   // Cuts a hang short well beyond the few thousand cycles the run needs.
   initial begin
      repeat (40000) @(posedge aclk);
      fail_count++;
      stop_test();
   end
   initial begin
      logic [31:0] r, d;
      logic [1:0] rsp;
      logic [11:0] b, hits;
      bebm_pkg::bebm_cyc_t c;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(bebm_pkg::CH_BASE, d, rsp);
      chk({rsp, d, trigger_probe_out}, {bebm_pkg::RESP_OKAY, bebm_pkg::CFG_RESET, 1'b1});
      rd(12'h0f0, d, rsp);
      chk({rsp, d}, {bebm_pkg::RESP_SLVERR, 32'h0});
      wr(12'h0f0, 32'h1, rsp);
      chk(rsp, bebm_pkg::RESP_SLVERR);
      for (int round = 0; round < 5; round++) begin
         for (int ch = 0; ch < 12; ch++) begin
            b = bebm_pkg::CH_BASE + bebm_pkg::CH_STRIDE * 12'(ch);
            r = xs();
            chs[ch].cfg = mkcfg();
            if (round == 0 && ch == 0) chs[ch].cfg = 32'h0000_01f3;
            if (round == 0 && ch == 7) chs[ch].cfg = 32'h0101_0001;
            if (round == 0 && ch == 11) chs[ch].cfg = 32'h0101_0019;
            chs[ch].lo = 32'h1000 + r[3:0];
            chs[ch].hi = chs[ch].lo + r[7:4];
            chs[ch].data = {8{r[9:8]}};
            chs[ch].mask = r[25:10];
            p3s[ch] = (r[27:26] == 2'h3) ? 2'h2 : r[27:26];
            wr(b, chs[ch].cfg, rsp);
            wr(b + 12'h4, chs[ch].lo, rsp);
            wr(b + 12'h8, chs[ch].hi, rsp);
            wr(b + 12'hc, {16'h0, chs[ch].data}, rsp);
            wr(b + 12'h10, {14'h0, p3s[ch], chs[ch].mask}, rsp);
            rd(b + 12'h10, d, rsp);
            chk(d, {14'h0, p3s[ch], chs[ch].mask});
         end
         r = xs();
         probe_in <= r[3:0];
         repeat (8) @(posedge aclk);
         for (int k = 0; k < 40; k++) begin
            r = xs();
            c = '0;
            c.addr = 32'h1000 + r[4:0];
            if (k == 0) c.addr = chs[0].lo;
            if (k == 1) c.addr = chs[1].hi;
            c.data = {8{r[6:5]}};
            c.write = r[7];
            c.word = r[8];
            c.fetch = r[9] | (k == 0);
            c.state = r[15:10];
            c.area = r[22:16];
            for (int ch = 0; ch < 12; ch++) hits[ch] = exp_hit(ch, chs[ch], c, probe_in, p3s[ch]);
            u_bus.send(c, int'(r[31:30]));
            #1 chk(match_out, hits);
            @(posedge aclk);
            #1 chk(trigger_probe_out, !hits[7]);
            seen |= hits;
            if (hits != 12'h0) last = hits;
         end
      end
      // The enable summary mirrors the enable bits of the last setup.
      for (int ch = 0; ch < 12; ch++) hits[ch] = chs[ch].cfg[0];
      rd(bebm_pkg::ENABLE_ALL, d, rsp);
      chk(d, {20'h0, hits});
      // Events stay sticky; the mask gates the level output until cleared.
      rd(bebm_pkg::IRQ_STATUS, d, rsp);
      chk({d, irq}, {20'h0, seen, 1'b0});
      rd(bebm_pkg::MATCH_LAST, d, rsp);
      chk(d, {20'h0, last});
      wr(bebm_pkg::IRQ_MASK, {20'h0, ~seen}, rsp);
      #1 chk(irq, 1'b0);
      wr(bebm_pkg::IRQ_MASK, 32'h0000_0fff, rsp);
      #1 chk(irq, seen != 12'h0);
      wr(bebm_pkg::IRQ_STATUS, {20'h0, seen}, rsp);
      #1 chk(irq, 1'b0);
      rd(bebm_pkg::IRQ_STATUS, d, rsp);
      chk(d, 32'h0);
      stop_test();
   end
endmodule : test_bus_event_breakpoint_matcher
`default_nettype wire
